// ---- hw/asl_core.sv ----
// Notes on behaviour
// RQ1: indirect index load into the selected register skips its modify
// RQ2: set pointer takes three low instruction bits
// RQ3: set pointer copies old pointer to backup
// RQ4: set pointer is modify instruction, indirect form
// RQ5: pointer also changed by status loads, indirect
// RQ6: indirect operands use register the pointer selects
// RQ7: long immediate loads unsigned, sign mode untouched
// RQ8: first status load keeps interrupt mask bit
// RQ9: first status load ignores next pointer field
// RQ10: first status load leaves backup field alone
// RQ11: short immediate zero-filled, no sign extension
// RQ12: page joins direct address into 16 bits
`include "asl_map.svh"
`default_nettype none
module asl_core
	import asl_pkg::*;
#(
	parameter int DMEM_ADDR_BITS = 8
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr
);

	asl_state_type   state_reg;
	asl_state_type   state_next;
	asl_mem_req_type mem_req;
	logic [15:0]     mem_rdata;

	asl_op_type  op;
	logic [15:0] instr;
	logic        indirect;
	logic [2:0]  ptr;
	logic [2:0]  target;
	logic [15:0] operand_addr;
	logic        setup_phase;
	logic        access_done;
	logic        wr_instr;
	logic        is_ar;
	logic        is_dmem;
	logic        mem_operand;
	logic        status_load;
	logic        next_ptr_en;
	logic [15:0] rd_word;
	logic        rd_err;

	function automatic asl_op_type asl_decode(input logic [15:0] w);
		asl_op_type r;
		r = ASL_OP_NONE;
		if (w[15:11] == `ASL_OPC_LAR)
		begin
			r = ASL_OP_LOAD_INDEX_MEM;
		end
		else if (w[15:11] == `ASL_OPC_INDEX_REG_LOAD_SHORT_IMMEDIATE)
		begin
			r = ASL_OP_LOAD_INDEX_SHORT;
		end
		else if (w[15:11] == `ASL_OPC_INDEX_REG_LOAD_LONG_IMMEDIATE && w[7:0] == 8'h00)
		begin
			r = ASL_OP_LOAD_INDEX_LONG;
		end
		else if (w[15:9] == `ASL_OPC_PAGE_LOAD_IMMEDIATE)
		begin
			r = ASL_OP_PAGE_IMM;
		end
		else
		begin
			case (w[15:8])
				`ASL_OPC_LST:  r = ASL_OP_FIRST_STATUS;
				`ASL_OPC_SECOND_STATUS_LOAD: r = ASL_OP_SECOND_STATUS;
				`ASL_OPC_LDP:  r = ASL_OP_PAGE_MEM;
				`ASL_OPC_LPH:  r = ASL_OP_PRODUCT_HIGH;
				`ASL_OPC_MAR:  r = ASL_OP_MODIFY_INDEX;
				default:       r = ASL_OP_NONE;
			endcase
		end
		return r;
	endfunction : asl_decode

	function automatic logic [15:0] asl_modify(
		input logic [15:0] v,
		input logic [1:0]  code
	);
		logic [15:0] r;
		r = v;
		// codes 00 and 11 leave the register as it is
		case (code)
			`ASL_MOD_DEC:
			begin
				r = v - 16'h0001;
			end
			`ASL_MOD_INC:
			begin
				r = v + 16'h0001;
			end
			default:
			begin
				r = v;
			end
		endcase
		return r;
	endfunction : asl_modify

	// operations that address data memory and so take the indirect field
	function automatic logic asl_mem_operand(input asl_op_type o);
		logic r;
		r = 1'b0;
		case (o)
			ASL_OP_LOAD_INDEX_MEM,
			ASL_OP_MODIFY_INDEX,
			ASL_OP_PAGE_MEM,
			ASL_OP_PRODUCT_HIGH,
			ASL_OP_FIRST_STATUS,
			ASL_OP_SECOND_STATUS:
			begin
				r = 1'b1;
			end
			default:
			begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction : asl_mem_operand

	// status loads bring their own pointer value with the word
	function automatic logic asl_status_load(input asl_op_type o);
		logic r;
		r = (o == ASL_OP_FIRST_STATUS) || (o == ASL_OP_SECOND_STATUS);
		return r;
	endfunction : asl_status_load

	// the instruction executes in the access cycle that writes it
	assign instr    = pwdata[15:0];
	assign op       = asl_decode(instr);
	assign indirect = instr[`ASL_IND_BIT];
	assign target   = instr[10:8];
	assign ptr      = state_reg.status_word_zero[`ASL_ST0_ARP_HI:`ASL_ST0_ARP_LO];

	// high page bits beyond the built memory are dropped by the memory
	assign operand_addr = indirect ? state_reg.index_register[ptr]   // [RQ6]
		: {state_reg.status_word_zero[`ASL_ST0_DP_HI:0], instr[6:0]}; // [RQ12]

	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && state_reg.pready;
	assign is_ar       = paddr[11:5] == `ASL_AR_PAGE;
	assign is_dmem     = paddr[11:10] == `ASL_DMEM_PAGE;
	assign wr_instr    = access_done && pwrite && !state_reg.pslverr
		&& paddr == `ASL_OFF_INSTR;

	assign mem_operand = asl_mem_operand(op);
	assign status_load = asl_status_load(op);
	// a next-pointer field on a status load would fight the loaded pointer
	assign next_ptr_en = indirect && instr[`ASL_NAR_EN] && mem_operand
		&& !status_load; // [RQ9]

	always_comb
	begin
		mem_req.we    = access_done && pwrite && is_dmem
			&& !state_reg.pslverr;
		mem_req.wdata = pwdata[15:0];
		mem_req.addr  = wr_instr ? operand_addr : {8'h00, paddr[9:2]};
	end

	asl_data_memory #(
		.ADDR_BITS (DMEM_ADDR_BITS)
	) u_dmem (
		.pclk  (pclk),
		.req   (mem_req),
		.rdata (mem_rdata)
	);

	// read mux is decoded in the setup cycle and registered for the access
	always_comb
	begin
		rd_word = 16'h0000;
		rd_err  = 1'b0;
		if (is_ar)
		begin
			rd_word = state_reg.index_register[paddr[4:2]];
		end
		else if (is_dmem)
		begin
			rd_word = mem_rdata;
		end
		else
		begin
			case (paddr)
				`ASL_OFF_INSTR:  rd_word = state_reg.last_instr;
				`ASL_OFF_SECOND: rd_word = state_reg.second_word;
				`ASL_OFF_ST0:    rd_word = state_reg.status_word_zero;
				`ASL_OFF_ST1:    rd_word = state_reg.status_word_one;
				`ASL_OFF_PRODH:  rd_word = state_reg.product_high;
				`ASL_OFF_COUNT:  rd_word = state_reg.exec_count;
				default:         rd_err  = 1'b1;
			endcase
		end
	end

	always_comb
	begin
		logic [2:0]  cur;
		logic [15:0] st0_new;
		cur        = 3'h0;
		st0_new    = 16'h0000;
		state_next = state_reg;
		state_next.pready  = 1'b0;
		state_next.pslverr = 1'b0;

		// zero wait state: answer comes in the first access cycle
		// prdata keeps its last value; only the pready cycle counts
		if (setup_phase)
		begin
			state_next.pready  = 1'b1;
			state_next.prdata  = {16'h0000, rd_word};
			state_next.pslverr = rd_err;
		end

		if (access_done && pwrite && !state_reg.pslverr)
		begin
			if (is_ar)
			begin
				state_next.index_register[paddr[4:2]] = pwdata[15:0];
			end
			else if (!is_dmem)
			begin
				case (paddr)
					`ASL_OFF_SECOND: state_next.second_word = pwdata[15:0];
					`ASL_OFF_ST0:
					begin
						state_next.status_word_zero = pwdata[15:0];
						state_next.status_word_zero[`ASL_ST0_ONE] = 1'b1;
					end
					`ASL_OFF_ST1:    state_next.status_word_one = pwdata[15:0];
					`ASL_OFF_PRODH:  state_next.product_high = pwdata[15:0];
					default:         state_next.exec_count = state_reg.exec_count;
				endcase
			end
		end

		if (wr_instr)
		begin
			state_next.last_instr = instr;
			state_next.exec_count = state_reg.exec_count + 16'h0001;
			cur = ptr;

			// post-modify of the selected register on indirect forms
			if (indirect && mem_operand)
			begin
				if (!(op == ASL_OP_LOAD_INDEX_MEM && target == cur)) // [RQ1]
				begin
					state_next.index_register[cur] = asl_modify(
						state_reg.index_register[cur],
						instr[`ASL_MOD_HI:`ASL_MOD_LO]);
				end
			end

			case (op)
				ASL_OP_LOAD_INDEX_MEM:
				begin
					state_next.index_register[target] = mem_rdata;
				end
				ASL_OP_LOAD_INDEX_SHORT:
				begin
					state_next.index_register[target] = {8'h00, instr[7:0]}; // [RQ11]
				end
				ASL_OP_LOAD_INDEX_LONG:
				begin
					// second word is used as is; sign mode bit not touched
					state_next.index_register[target] = state_reg.second_word; // [RQ7]
				end
				ASL_OP_PAGE_MEM:
				begin
					state_next.status_word_zero[`ASL_ST0_DP_HI:0] = mem_rdata[8:0]; // [RQ12]
				end
				ASL_OP_PAGE_IMM:
				begin
					state_next.status_word_zero[`ASL_ST0_DP_HI:0] = instr[8:0]; // [RQ12]
				end
				ASL_OP_PRODUCT_HIGH:
				begin
					state_next.product_high = mem_rdata;
				end
				ASL_OP_FIRST_STATUS:
				begin
					st0_new = mem_rdata;
					st0_new[`ASL_ST0_INTERRUPT_MASK] = state_reg.status_word_zero[`ASL_ST0_INTERRUPT_MASK]; // [RQ8]
					st0_new[`ASL_ST0_ONE] = 1'b1;
					// pointer comes from the word, backup untouched
					state_next.status_word_zero = st0_new; // [RQ9] [RQ10] [RQ5]
				end
				ASL_OP_SECOND_STATUS:
				begin
					state_next.status_word_one = mem_rdata;
					// restored backup is also moved into the pointer
					state_next.status_word_zero[`ASL_ST0_ARP_HI:`ASL_ST0_ARP_LO] =
						mem_rdata[`ASL_ST1_ARB_HI:`ASL_ST1_ARB_LO]; // [RQ5]
				end
				default:
				begin
					state_next.exec_count = state_reg.exec_count + 16'h0001;
				end
			endcase

			// next-pointer field of indirect forms; status loads ignore it
			if (next_ptr_en)
			begin
				state_next.status_word_one[`ASL_ST1_ARB_HI:`ASL_ST1_ARB_LO] =
					cur; // [RQ3] [RQ4]
				state_next.status_word_zero[`ASL_ST0_ARP_HI:`ASL_ST0_ARP_LO] =
					instr[2:0]; // [RQ2] [RQ5] [RQ6]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg                  <= '0;
			state_reg.status_word_zero <= `ASL_ST0_RST;
			state_reg.status_word_one  <= `ASL_ST1_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign pready  = state_reg.pready;
	assign prdata  = state_reg.prdata;
	assign pslverr = state_reg.pslverr;

endmodule : asl_core
`default_nettype wire

// ---- hw/asl_map.svh ----
`ifndef ASL_MAP_SVH
`define ASL_MAP_SVH

// register byte offsets on the apb window
`define ASL_OFF_INSTR      12'h000
`define ASL_OFF_SECOND     12'h004
`define ASL_OFF_ST0        12'h008
`define ASL_OFF_ST1        12'h00C
`define ASL_OFF_PRODH      12'h010
`define ASL_OFF_COUNT      12'h014
`define ASL_AR_PAGE        7'h01
`define ASL_DMEM_PAGE      2'h1

// status word fields
`define ASL_ST0_ARP_HI     15
`define ASL_ST0_ARP_LO     13
`define ASL_ST0_ONE        10
`define ASL_ST0_INTERRUPT_MASK       9
`define ASL_ST0_DP_HI      8
`define ASL_ST1_ARB_HI     15
`define ASL_ST1_ARB_LO     13
`define ASL_ST1_SXM        10

// reset values
`define ASL_ST0_RST        16'h0600
`define ASL_ST1_RST        16'h0000

// opcode patterns
`define ASL_OPC_LAR        5'h06
`define ASL_OPC_INDEX_REG_LOAD_SHORT_IMMEDIATE       5'h18
`define ASL_OPC_INDEX_REG_LOAD_LONG_IMMEDIATE       5'h1A
`define ASL_OPC_PAGE_LOAD_IMMEDIATE       7'h64
`define ASL_OPC_LST        8'h50
`define ASL_OPC_SECOND_STATUS_LOAD       8'h51
`define ASL_OPC_LDP        8'h52
`define ASL_OPC_LPH        8'h53
`define ASL_OPC_MAR        8'h55

// indirect field: modify code and next-pointer enable
`define ASL_IND_BIT        7
`define ASL_MOD_HI         5
`define ASL_MOD_LO         4
`define ASL_NAR_EN         3
`define ASL_MOD_DEC        2'h1
`define ASL_MOD_INC        2'h2

`endif

// ---- hw/asl_pkg.sv ----
`default_nettype none
package asl_pkg;

	typedef enum logic [3:0] {
		ASL_OP_NONE,
		ASL_OP_LOAD_INDEX_MEM,
		ASL_OP_LOAD_INDEX_SHORT,
		ASL_OP_LOAD_INDEX_LONG,
		ASL_OP_MODIFY_INDEX,
		ASL_OP_PAGE_MEM,
		ASL_OP_PAGE_IMM,
		ASL_OP_PRODUCT_HIGH,
		ASL_OP_FIRST_STATUS,
		ASL_OP_SECOND_STATUS
	} asl_op_type;

	typedef struct packed {
		logic [7:0][15:0] index_register;
		logic [15:0]      status_word_zero;
		logic [15:0]      status_word_one;
		logic [15:0]      product_high;
		logic [15:0]      second_word;
		logic [15:0]      last_instr;
		logic [15:0]      exec_count;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} asl_state_type;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} asl_mem_req_type;

endpackage : asl_pkg
`default_nettype wire

// ---- hw/asl_data_memory.sv ----
`default_nettype none
module asl_data_memory
	import asl_pkg::*;
#(
	parameter int ADDR_BITS = 8
)
(
	input  wire logic            pclk,
	input  wire asl_mem_req_type req,
	output logic [15:0]          rdata
);

	logic [15:0] mem_array [0:(1 << ADDR_BITS) - 1];

	// no reset: contents are undefined until software fills them
	always_ff @(posedge pclk)
	begin
		if (req.we)
		begin
			mem_array[req.addr[ADDR_BITS-1:0]] <= req.wdata;
		end
	end

	// combinational read so an instruction completes in one cycle
	assign rdata = mem_array[req.addr[ADDR_BITS-1:0]];

endmodule : asl_data_memory
`default_nettype wire

// ---- sim/asl_core_chk.sv ----
`default_nettype none
module asl_core_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr
);
	logic       acc;
	logic       pk_reg;
	logic       ak_reg;
	logic [2:0] k_reg;
	logic [2:0] a_reg;
	logic [7:0] c_reg;
	assign acc = psel & penable & pready;
	// any later instruction may move the pointer, so only the latest counts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pk_reg <= 1'b0;
			ak_reg <= 1'b0;
			k_reg  <= 3'h0;
			a_reg  <= 3'h0;
			c_reg  <= 8'h00;
		end
		else if (acc && pwrite)
		begin
			if (paddr == 12'h000)
			begin
				pk_reg <= pwdata[15:3] == 13'h0AB1;
				ak_reg <= pwdata[15:11] == 5'h18;
				k_reg  <= pwdata[2:0];
				a_reg  <= pwdata[10:8];
				c_reg  <= pwdata[7:0];
			end
			else
			begin
				pk_reg <= pk_reg & (paddr != 12'h008);
				ak_reg <= ak_reg & (paddr[11:5] != 7'h01);
			end
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd;
		acc && !pwrite;
	endsequence
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_idle_no_ready: assert property (!psel |=> !pready)
		else $error("ready without request");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_unmapped_err: assert property (s_setup ##0 paddr == 12'h018 |=> pslverr)
		else $error("unmapped access not refused");
	a_ptr_set_read: assert property (s_rd ##0 (paddr == 12'h008 && pk_reg)
		|-> prdata[15:13] == k_reg)
		else $error("pointer not taken from low bits");
	a_short_imm_read: assert property (s_rd ##0
		(ak_reg && paddr == {7'h01, a_reg, 2'b00})
		|-> prdata[15:0] == {8'h00, c_reg})
		else $error("short constant not zero filled");
endmodule : asl_core_chk
bind asl_core asl_core_chk chk_i (
	.pclk    (pclk),
	.presetn (presetn),
	.psel    (psel),
	.penable (penable),
	.pwrite  (pwrite),
	.paddr   (paddr),
	.pwdata  (pwdata),
	.pready  (pready),
	.prdata  (prdata),
	.pslverr (pslverr)
);
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [15:0] d;
	} asl_row_type;
	logic        pclk;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        er;
	asl_row_type rows [47] = '{
		'{1'h1,12'h000,16'hC1FF},
		'{1'h0,12'h024,16'h00FF},
		'{1'h1,12'h004,16'h8001},
		'{1'h1,12'h000,16'hD200},
		'{1'h0,12'h028,16'h8001},
		'{1'h0,12'h00C,16'h0000},
		'{1'h1,12'h000,16'h558B},
		'{1'h0,12'h008,16'h6600},
		'{1'h1,12'h000,16'h558D},
		'{1'h0,12'h00C,16'h6000},
		'{1'h1,12'h000,16'hC805},
		'{1'h0,12'h008,16'hA605},
		'{1'h1,12'h000,16'hC801},
		'{1'h1,12'h614,16'h1234},
		'{1'h1,12'h618,16'h00AB},
		'{1'h1,12'h000,16'h3005},
		'{1'h0,12'h020,16'h1234},
		'{1'h1,12'h000,16'hC585},
		'{1'h1,12'h000,16'h31A0},
		'{1'h0,12'h024,16'h1234},
		'{1'h0,12'h034,16'h0086},
		'{1'h1,12'h000,16'h3590},
		'{1'h0,12'h034,16'h00AB},
		'{1'h1,12'h61C,16'h4003},
		'{1'h1,12'h000,16'h5007},
		'{1'h0,12'h008,16'h4603},
		'{1'h0,12'h00C,16'h6000},
		'{1'h1,12'h404,16'hE005},
		'{1'h1,12'h000,16'h508C},
		'{1'h0,12'h008,16'hE605},
		'{1'h0,12'h00C,16'h6000},
		'{1'h1,12'h620,16'h2000},
		'{1'h1,12'h000,16'h5108},
		'{1'h0,12'h00C,16'h2000},
		'{1'h0,12'h008,16'h2605},
		'{1'h1,12'h628,16'h01F3},
		'{1'h1,12'h000,16'h520A},
		'{1'h0,12'h008,16'h27F3},
		'{1'h1,12'h62C,16'hBEEF},
		'{1'h1,12'h000,16'h530B},
		'{1'h0,12'h010,16'hBEEF},
		'{1'h1,12'h000,16'h55AE},
		'{1'h0,12'h024,16'h1235},
		'{1'h0,12'h008,16'hC7F3},
		'{1'h1,12'h014,16'hFFFF},
		'{1'h0,12'h014,16'h0010},
		'{1'h0,12'h000,16'h55AE}
	};
	asl_core dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr)
	);
	task automatic finish_test();
		if (failures == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// no release here, so psel stays high across back-to-back calls
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [15:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
	endtask : apb
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			finish_test();
		end
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
			if (!rows[i].w)
			begin
				chk(rd, {16'h0000, rows[i].d});
				chk({31'h0, er}, 32'h0);
			end
		end
		apb(1'b0, 12'h018, 16'h0000, rd, er);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h018, 16'hFFFF, rd, er);
		chk({31'h0, er}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h008, 16'h0000, rd, er);
		chk(rd, 32'h00000600);
		apb(1'b0, 12'h00C, 16'h0000, rd, er);
		chk(rd, 32'h00000000);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
